/* File: logic/instr_exec_defs.vh */
// Constants of the serial, separator, difference and interrupt-gate executor
// Included by the executor and its helper modules; definitions only
`ifndef INSTR_EXEC_DEFS_VH
`define INSTR_EXEC_DEFS_VH

// Opcode encodings of the handled instructions
`define OPC_SERIAL_RX 8'h2D
`define OPC_SERIAL_TX 8'h2E
`define OPC_SECTION_SEP 8'h97
`define OPC_PLAIN_DIFF 8'h92
`define OPC_OFFSET_DIFF 8'h93
`define OPC_IRQ_OFF 8'h98
`define OPC_IRQ_ON 8'h99
`define OPC_MASTER_IRQ_OFF 8'h9A
`define OPC_MASTER_IRQ_ON 8'h9B

// Cycle counts per instruction
`define CYC_SERIAL 4'h5
`define CYC_SECTION 4'h4
`define CYC_DIFF 4'h7
`define CYC_IRQ 4'h4

// Instruction lengths in bytes
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2

// Offset-binary zero code
`define OFFSET_ZERO 10'h080

// Reset values
`define RST_USER_IRQ_EN 1'b1
`define RST_MASTER_IRQ_EN 1'b1
`define RST_SECTION 2'h0

// Section codes
`define SEC_ARITH 2'h0
`define SEC_FUZZY 2'h1
`define SEC_IRQ_SPEC 2'h2

`endif

/* File: logic/diff_unit.v */
// Difference unit: plain and offset-binary subtraction with flag results
// Combinational; operands come from the register file of the same clock
`timescale 1ns/10ps
`include "instr_exec_defs.vh"

module diff_unit (
    // Operands
    input wire [7:0] dest_i,
    input wire [7:0] src_i,
    input wire offset_i,
    // Results
    output reg [7:0] result_o,
    output reg null_o,
    output reg wrap_o
);
    reg [9:0] wide;
    reg over;
    reg under;

    always @* begin
        wide = 10'h000;
        over = 1'b0;
        under = 1'b0;
        if (offset_i) begin
            // Ten-bit signed view of dest - src + 128
            wide = {2'b00, dest_i} - {2'b00, src_i} + `OFFSET_ZERO;
            under = wide[9];
            over = !wide[9] && wide[8];
            result_o = wide[7:0];
            null_o = (wide[7:0] == 8'h00 && !under) || over;
            wrap_o = under || over;
        end else begin
            under = src_i > dest_i;
            result_o = dest_i - src_i;
            null_o = (result_o == 8'h00);
            wrap_o = under;
        end
    end
endmodule // diff_unit

/* File: logic/irq_gate.v */
// Interrupt acknowledge gate driven by the user and master global enables
// Pending requests and priority are held outside; this only gates them
`timescale 1ns/10ps
`include "instr_exec_defs.vh"

module irq_gate (
    // Enables
    input wire user_en_i,
    input wire master_en_i,
    // Requests
    input wire [7:0] pending_i,
    input wire [7:0] mask_i,
    // Acknowledge permission per line
    output wire [7:0] may_ack_o
);
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gate
            // Cleared enable leaves requests pending, unacknowledged
            assign may_ack_o[g] = pending_i[g] && mask_i[g] && user_en_i && master_en_i;
        end
    endgenerate
endmodule // irq_gate

/* File: logic/instr_exec.v */
// Executor for serial read/load, section separator, differences, irq gating
// Fetch presents opcode and operand byte with a start pulse; runs on one clock
`timescale 1ns/10ps
`include "instr_exec_defs.vh"

module instr_exec (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Instruction from fetch
    input wire start_i,
    input wire [7:0] opcode_i,
    input wire [7:0] operand_i,
    // Serial unit holding registers
    input wire [7:0] serial_rx_holding_reg_i,
    output reg [7:0] serial_tx_holding_reg_o,
    output reg tx_start_o,
    // Interrupt requests
    input wire [7:0] irq_pending_i,
    input wire [7:0] irq_mask_i,
    output reg [7:0] irq_may_ack_o,
    // Status
    output reg busy_o,
    output reg done_o,
    output reg [1:0] length_o,
    output reg illegal_o,
    output reg flag_null_o,
    output reg flag_wrap_o,
    output reg user_global_irq_enable_bit_o,
    output reg master_irq_enable_o,
    output reg [1:0] section_o,
    // Register file observation
    input wire [3:0] peek_addr_i,
    output reg [7:0] peek_data_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;

    reg [1:0] state;
    reg [3:0] count;
    reg [7:0] op;
    reg [3:0] dst;
    reg [3:0] src;
    reg [7:0] regfile [0:15];
    reg [1:0] last_code_sec;
    wire [7:0] diff_result;
    wire diff_null;
    wire diff_wrap;
    wire [7:0] may_ack;
    reg [3:0] next_count;
    reg [1:0] next_len;
    reg legal;
    integer k;

    diff_unit u_diff (
        .dest_i(regfile[dst]),
        .src_i(regfile[src]),
        .offset_i(op == `OPC_OFFSET_DIFF),
        .result_o(diff_result),
        .null_o(diff_null),
        .wrap_o(diff_wrap)
    );

    irq_gate u_gate (
        .user_en_i(user_global_irq_enable_bit_o),
        .master_en_i(master_irq_enable_o),
        .pending_i(irq_pending_i),
        .mask_i(irq_mask_i),
        .may_ack_o(may_ack)
    );

    // Cycle count and length of a new opcode
    always @* begin
        next_count = 4'h0;
        next_len = `LEN_ONE;
        legal = 1'b1;
        case (opcode_i)
            `OPC_SERIAL_RX, `OPC_SERIAL_TX: begin
                next_count = `CYC_SERIAL;
                next_len = `LEN_TWO;
            end
            `OPC_SECTION_SEP: begin
                next_count = `CYC_SECTION;
            end
            `OPC_PLAIN_DIFF, `OPC_OFFSET_DIFF: begin
                next_count = `CYC_DIFF;
                next_len = `LEN_TWO;
            end
            `OPC_IRQ_OFF, `OPC_IRQ_ON, `OPC_MASTER_IRQ_OFF, `OPC_MASTER_IRQ_ON: begin
                next_count = `CYC_IRQ;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            count <= 4'h0;
            op <= 8'h00;
            dst <= 4'h0;
            src <= 4'h0;
            last_code_sec <= `SEC_ARITH;
            serial_tx_holding_reg_o <= 8'h00;
            tx_start_o <= 1'b0;
            irq_may_ack_o <= 8'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            length_o <= 2'h0;
            illegal_o <= 1'b0;
            flag_null_o <= 1'b0;
            flag_wrap_o <= 1'b0;
            user_global_irq_enable_bit_o <= `RST_USER_IRQ_EN;
            master_irq_enable_o <= `RST_MASTER_IRQ_EN;
            section_o <= `RST_SECTION;
            peek_data_o <= 8'h00;
            for (k = 0; k < 16; k = k + 1) begin
                regfile[k] <= 8'h00;
            end
        end else begin
            tx_start_o <= 1'b0;
            done_o <= 1'b0;
            illegal_o <= 1'b0;
            irq_may_ack_o <= may_ack;
            peek_data_o <= regfile[peek_addr_i];
            case (state)
                ST_IDLE: begin
                    if (start_i) begin
                        if (legal) begin
                            state <= ST_RUN;
                            op <= opcode_i;
                            dst <= operand_i[7:4];
                            src <= operand_i[3:0];
                            count <= next_count - 4'h1;
                            length_o <= next_len;
                            busy_o <= 1'b1;
                        end else begin
                            illegal_o <= 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    if (count != 4'h1) begin
                        count <= count - 4'h1;
                    end else begin
                        // Effects land in the final cycle of the instruction
                        state <= ST_IDLE;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        count <= 4'h0;
                        case (op)
                            `OPC_SERIAL_RX: begin
                                regfile[dst] <= serial_rx_holding_reg_i;
                            end
                            `OPC_SERIAL_TX: begin
                                serial_tx_holding_reg_o <= regfile[dst];
                                tx_start_o <= 1'b1;
                            end
                            `OPC_SECTION_SEP: begin
                                if (section_o == `SEC_IRQ_SPEC) begin
                                    section_o <= last_code_sec;
                                end else if (section_o == `SEC_ARITH) begin
                                    section_o <= `SEC_FUZZY;
                                    last_code_sec <= `SEC_FUZZY;
                                end else begin
                                    section_o <= `SEC_ARITH;
                                    last_code_sec <= `SEC_ARITH;
                                end
                            end
                            `OPC_PLAIN_DIFF, `OPC_OFFSET_DIFF: begin
                                regfile[dst] <= diff_result;
                                flag_null_o <= diff_null;
                                flag_wrap_o <= diff_wrap;
                            end
                            `OPC_IRQ_OFF: begin
                                user_global_irq_enable_bit_o <= 1'b0;
                            end
                            `OPC_IRQ_ON: begin
                                user_global_irq_enable_bit_o <= 1'b1;
                            end
                            `OPC_MASTER_IRQ_OFF: begin
                                master_irq_enable_o <= 1'b0;
                            end
                            `OPC_MASTER_IRQ_ON: begin
                                master_irq_enable_o <= 1'b1;
                            end
                            default: begin
                                op <= 8'h00;
                            end
                        endcase
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // instr_exec

/* File: tb/instr_exec_monitor.sv */
// Port-level assertions for the instruction executor
// Bound to every instr_exec instance; one clock domain, async reset
`timescale 1ns/10ps
`include "instr_exec_defs.vh"
module instr_exec_monitor (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Instruction
    input wire start_i,
    input wire [7:0] opcode_i,
    // Serial and interrupts
    input wire [7:0] serial_tx_holding_reg_o,
    input wire tx_start_o,
    input wire [7:0] irq_pending_i,
    input wire [7:0] irq_mask_i,
    input wire [7:0] irq_may_ack_o,
    // Status
    input wire busy_o,
    input wire done_o,
    input wire flag_null_o,
    input wire flag_wrap_o,
    input wire user_global_irq_enable_bit_o,
    input wire master_irq_enable_o,
    input wire [1:0] section_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    wire take = start_i && !busy_o;
    wire both_en = user_global_irq_enable_bit_o && master_irq_enable_o;

    chk_sub_seven: assert property (take && opcode_i == `OPC_PLAIN_DIFF
        |=> busy_o [*6] ##1 done_o && !busy_o) else $error("plain diff timing");
    chk_offset_seven: assert property (take && opcode_i == `OPC_OFFSET_DIFF
        |-> ##7 done_o) else $error("offset diff timing");
    chk_serial_five: assert property (take && (opcode_i == `OPC_SERIAL_RX
        || opcode_i == `OPC_SERIAL_TX) |-> ##5 done_o) else $error("serial timing");
    chk_sep_toggles: assert property (take && opcode_i == `OPC_SECTION_SEP
        |-> ##4 done_o && section_o != $past(section_o, 4)) else $error("separator");
    chk_irq_off_four: assert property (take && opcode_i == `OPC_IRQ_OFF
        |-> ##4 done_o && !user_global_irq_enable_bit_o) else $error("irq off");
    chk_flags_at_done: assert property ($changed(flag_null_o) || $changed(flag_wrap_o)
        |-> done_o) else $error("flags moved outside done");
    chk_tx_with_pulse: assert property ($changed(serial_tx_holding_reg_o)
        |-> tx_start_o && done_o) else $error("tx holding without pulse");
    chk_gate_closed: assert property (!both_en && $past(!both_en)
        |-> irq_may_ack_o == 8'h00) else $error("ack while disabled");
    chk_gate_open: assert property ($past(!reset_i) && both_en && $past(both_en)
        |-> irq_may_ack_o == $past(irq_pending_i & irq_mask_i)) else $error("ack mismatch");

    cover property (done_o && tx_start_o);
    cover property (take && opcode_i == `OPC_OFFSET_DIFF);
    cover property ($fell(user_global_irq_enable_bit_o));
endmodule // instr_exec_monitor

bind instr_exec instr_exec_monitor mon_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(start_i),
    .opcode_i(opcode_i),
    .serial_tx_holding_reg_o(serial_tx_holding_reg_o),
    .tx_start_o(tx_start_o),
    .irq_pending_i(irq_pending_i),
    .irq_mask_i(irq_mask_i),
    .irq_may_ack_o(irq_may_ack_o),
    .busy_o(busy_o),
    .done_o(done_o),
    .flag_null_o(flag_null_o),
    .flag_wrap_o(flag_wrap_o),
    .user_global_irq_enable_bit_o(user_global_irq_enable_bit_o),
    .master_irq_enable_o(master_irq_enable_o),
    .section_o(section_o)
);

/* File: tb/instr_exec_tb_top.sv */
// Directed bench for the instruction executor
// Inputs change at the falling edge; register file loaded via serial reads
`timescale 1ns/10ps
`include "instr_exec_defs.vh"
module instr_exec_tb_top;
    reg clk_i, reset_i, start_i;
    reg [7:0] opc, opd, rx, pend, mask;
    reg [3:0] paddr;
    wire [7:0] tx, ack, pdata;
    wire txs, busy, done, ill, z, s, uen, men;
    wire [1:0] len, sec;
    integer num_errors, cmp_count;
    instr_exec dut_u (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .opcode_i(opc),
        .operand_i(opd), .serial_rx_holding_reg_i(rx), .serial_tx_holding_reg_o(tx),
        .tx_start_o(txs), .irq_pending_i(pend), .irq_mask_i(mask), .irq_may_ack_o(ack),
        .busy_o(busy), .done_o(done), .length_o(len), .illegal_o(ill), .flag_null_o(z),
        .flag_wrap_o(s), .user_global_irq_enable_bit_o(uen), .master_irq_enable_o(men),
        .section_o(sec), .peek_addr_i(paddr), .peek_data_o(pdata));
    task complete_run;
        begin
            $display("errors %0d comparisons %0d", num_errors, cmp_count);
            if (num_errors == 0 && cmp_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp, input string nm);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Issues one instruction and checks its cycle count and length
    task exec(input [7:0] op, input [7:0] b, input [7:0] n, input [1:0] l);
        integer i;
        begin
            @(negedge clk_i);
            start_i = 1'b1;
            opc = op;
            opd = b;
            @(negedge clk_i);
            start_i = 1'b0;
            i = 0;
            while (done !== 1'b1 && i < 20) begin
                @(posedge clk_i);
                #1 i = i + 1;
            end
            if (i == 20) begin
                num_errors = num_errors + 1;
                complete_run;
            end
            check(i, n - 8'h01, "cycles");
            check(len, l, "length");
        end
    endtask
    task load(input [3:0] a, input [7:0] v);
        begin
            @(negedge clk_i);
            rx = v;
            exec(`OPC_SERIAL_RX, {a, 4'h0}, 8'h05, `LEN_TWO);
        end
    endtask
    task peek(input [3:0] a, input [7:0] exp);
        begin
            @(negedge clk_i);
            paddr = a;
            @(posedge clk_i);
            #1 check(pdata, exp, "entry");
        end
    endtask
    task run_diff(input [7:0] op, input [7:0] d, input [7:0] sv, input [7:0] r,
        input zf, input wf);
        begin
            load(4'h4, d);
            load(4'hB, sv);
            exec(op, 8'h4B, 8'h07, `LEN_TWO);
            check(z, zf, "null");
            check(s, wf, "wrap");
            peek(4'h4, r);
        end
    endtask
    task s_diff;
        begin
            run_diff(`OPC_PLAIN_DIFF, 8'h2D, 8'h0F, 8'h1E, 1'b0, 1'b0);
            run_diff(`OPC_PLAIN_DIFF, 8'h64, 8'hC8, 8'h9C, 1'b0, 1'b1);
            run_diff(`OPC_PLAIN_DIFF, 8'h0F, 8'h0F, 8'h00, 1'b1, 1'b0);
            run_diff(`OPC_OFFSET_DIFF, 8'h2D, 8'h0F, 8'h9E, 1'b0, 1'b0);
            run_diff(`OPC_OFFSET_DIFF, 8'h00, 8'h80, 8'h00, 1'b1, 1'b0);
            run_diff(`OPC_OFFSET_DIFF, 8'h32, 8'hC8, 8'hEA, 1'b0, 1'b1);
            run_diff(`OPC_OFFSET_DIFF, 8'hC8, 8'h32, 8'h16, 1'b1, 1'b1);
        end
    endtask
    // Flags stay set from the last offset overflow through these
    task s_serial_sep;
        begin
            load(4'h4, 8'h5A);
            exec(`OPC_SERIAL_TX, 8'h40, 8'h05, `LEN_TWO);
            check(tx, 8'h5A, "tx holding");
            check(txs, 1'b1, "tx pulse");
            exec(`OPC_SECTION_SEP, 8'h00, 8'h04, `LEN_ONE);
            check(sec, `SEC_FUZZY, "section");
            exec(`OPC_SECTION_SEP, 8'h00, 8'h04, `LEN_ONE);
            check(sec, `SEC_ARITH, "section");
            check({z, s}, 2'h3, "flags kept");
        end
    endtask
    task s_irq;
        begin
            check(ack, 8'h05, "ack open");
            exec(`OPC_IRQ_OFF, 8'h00, 8'h04, `LEN_ONE);
            check(uen, 1'b0, "user en");
            repeat (2) @(posedge clk_i);
            #1 check(ack, 8'h00, "ack held");
            exec(`OPC_MASTER_IRQ_OFF, 8'h00, 8'h04, `LEN_ONE);
            exec(`OPC_IRQ_ON, 8'h00, 8'h04, `LEN_ONE);
            check(uen, 1'b1, "user en");
            repeat (2) @(posedge clk_i);
            #1 check(ack, 8'h00, "ack master off");
            exec(`OPC_MASTER_IRQ_ON, 8'h00, 8'h04, `LEN_ONE);
            repeat (2) @(posedge clk_i);
            #1 check(ack, 8'h05, "ack again");
            check({z, s}, 2'h3, "flags kept");
        end
    endtask
    // Unknown opcode gives a one-cycle illegal pulse and starts nothing
    task s_illegal;
        begin
            @(negedge clk_i);
            start_i = 1'b1;
            opc = 8'h00;
            @(posedge clk_i);
            #1 check({ill, busy}, 2'h2, "illegal pulse");
            @(negedge clk_i);
            start_i = 1'b0;
            @(posedge clk_i);
            #1 check({ill, busy, done}, 3'h0, "illegal ends");
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        num_errors = 0;
        cmp_count = 0;
        reset_i = 1'b1;
        start_i = 1'b0;
        opc = 8'h00;
        opd = 8'h00;
        rx = 8'h00;
        pend = 8'h0F;
        mask = 8'h05;
        paddr = 4'h0;
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        check({uen, men, sec, busy}, 5'h18, "reset state");
        s_diff;
        s_serial_sep;
        s_irq;
        s_illegal;
        complete_run;
    end
endmodule // instr_exec_tb_top
